// ### rtl/pcs_cfg.svh
`ifndef PCS_CFG_SVH
`define PCS_CFG_SVH

// register bus geometry: 16-bit word addresses, 16-bit data
`define PCS_ADDR_W              16
`define PCS_DATA_W              16

// register offsets (word addresses)
`define PCS_OFS_GATE_A          16'h1C02
`define PCS_OFS_GATE_B          16'h1C03
`define PCS_OFS_STOP_HS         16'h1C3A
`define PCS_OFS_CLKGEN          16'h1C3C

// clock_stop_handshake field positions
`define PCS_BIT_MEMIF_REQ       0
`define PCS_BIT_MEMIF_ACK       1
`define PCS_BIT_USB_REQ         2
`define PCS_BIT_USB_ACK         3
`define PCS_BIT_UART_REQ        4
`define PCS_BIT_UART_ACK        5

// periph_gate_reg_a field positions
`define PCS_BIT_GATE_MEMIF      1
`define PCS_BIT_GATE_UART       3
// periph_gate_reg_b field positions
`define PCS_BIT_GATE_USB        2

// clock generator control field positions
`define PCS_BIT_CG_BYPASS       0
`define PCS_BIT_CG_SRC_RTC      1
`define PCS_BIT_CG_PLL_PDN      2

// reset values
`define PCS_RST_STOP_REQ        1'b1
`define PCS_RST_GATE_A          16'h0000
`define PCS_RST_GATE_B          16'h0000
`define PCS_RST_CLKGEN          3'h0

`endif

// ### rtl/pcs_pkg.sv
package pcs_pkg;

    // handshake progress of one peripheral
    typedef enum logic [1:0] {
        PCS_RUN,
        PCS_DRAIN,
        PCS_HALTED
    } pcs_stop_state_e;

endpackage

// ### rtl/pcs_stop_agent.sv
`timescale 1ns/10ps

// peripheral-side half of the clock stop handshake
module pcs_stop_agent
    import pcs_pkg::*;
(
    // clock and reset
    input  wire logic core_clk_i,
    input  wire logic srst_i,
    // handshake
    input  wire logic stop_req_i,   // request bit from firmware
    input  wire logic bus_busy_i,   // peripheral has a bus transaction open
    output logic      stop_ack_o    // permission to gate the clock
);

    pcs_stop_state_e state;         // handshake state

    // a request waits in drain until the open transaction closes
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            state <= PCS_HALTED;
        end else begin
            unique case (state)
                PCS_RUN: begin
                    if (stop_req_i) begin
                        state <= PCS_DRAIN;
                    end
                end
                PCS_DRAIN: begin
                    if (!stop_req_i) begin
                        state <= PCS_RUN;
                    end else if (!bus_busy_i) begin
                        state <= PCS_HALTED;
                    end
                end
                PCS_HALTED: begin
                    if (!stop_req_i) begin
                        state <= PCS_RUN;
                    end
                end
            endcase
        end
    end

    // ack flop: reset value 1, set only once drained, dropped on release
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            stop_ack_o <= 1'b1;
        end else begin
            stop_ack_o <= stop_req_i &&
                          ((state == PCS_HALTED) ||
                           (state == PCS_DRAIN && !bus_busy_i));
        end
    end

endmodule // pcs_stop_agent

// ### rtl/pcs_clock_stop.sv
`timescale 1ns/10ps
`include "pcs_cfg.svh"

// Summary of operation
// - peripheral drains open bus transaction before ack
// - one request and one ack bit each
// - bit 5 uart ack, read-only, resets 1
// - bit 4 uart request, read/write, resets 1
// - bit 3 usb ack, read-only, resets 1
// - bit 2 usb request, read/write, resets 1
// - gating writes take effect at once
// - bypass sources system clock from pin or rtc
// - pll runs in bypass unless powered down
// - gating bit 1 stops clock, 0 runs
module pcs_clock_stop
    import pcs_pkg::*;
(
    // clock and reset
    input  wire logic                   core_clk_i,
    input  wire logic                   srst_i,
    // register port
    input  wire logic [`PCS_ADDR_W-1:0] reg_addr_i,
    input  wire logic [`PCS_DATA_W-1:0] reg_wdata_i,
    input  wire logic                   reg_wr_i,
    input  wire logic                   reg_rd_i,
    output logic      [`PCS_DATA_W-1:0] reg_rdata_o,
    // peripheral activity, same clock domain
    input  wire logic                   memif_busy_i,
    input  wire logic                   usb_busy_i,
    input  wire logic                   serial_port_busy_i,
    // stop requests towards the peripherals
    output logic                        memif_stop_req_o,
    output logic                        usb_stop_req_o,
    output logic                        serial_port_stop_req_o,
    // clock gate controls, 1 = clock stopped
    output logic                        memif_clk_gate_o,
    output logic                        usb_clk_gate_o,
    output logic                        serial_port_clk_gate_o,
    // clock generator controls
    output logic                        clkgen_bypass_o,
    output logic                        system_clock_from_rtc_o,
    output logic                        pll_pwrdn_o
);

    ////////////////////////////////////////////////////////////////////////////
    // address decode

    // one compare per register, shared by the write and read paths
    function automatic logic hit(input logic [`PCS_ADDR_W-1:0] addr,
                                 input logic [`PCS_ADDR_W-1:0] ofs);
        hit = (addr == ofs);
    endfunction

    logic wr_stop_hs;                   // write to clock_stop_handshake
    logic wr_gate_a;                    // write to periph_gate_reg_a
    logic wr_gate_b;                    // write to periph_gate_reg_b
    logic wr_clkgen;                    // write to clock generator control

    assign wr_stop_hs = reg_wr_i && hit(reg_addr_i, `PCS_OFS_STOP_HS);
    assign wr_gate_a  = reg_wr_i && hit(reg_addr_i, `PCS_OFS_GATE_A);
    assign wr_gate_b  = reg_wr_i && hit(reg_addr_i, `PCS_OFS_GATE_B);
    assign wr_clkgen  = reg_wr_i && hit(reg_addr_i, `PCS_OFS_CLKGEN);

    ////////////////////////////////////////////////////////////////////////////
    // stop request bits

    // requests reset high: every peripheral starts out parked and acked;
    // writes to the ack positions are simply dropped since acks are read-only
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            memif_stop_req_o       <= `PCS_RST_STOP_REQ;
            usb_stop_req_o         <= `PCS_RST_STOP_REQ;
            serial_port_stop_req_o <= `PCS_RST_STOP_REQ;
        end else if (wr_stop_hs) begin
            memif_stop_req_o       <= reg_wdata_i[`PCS_BIT_MEMIF_REQ];
            usb_stop_req_o         <= reg_wdata_i[`PCS_BIT_USB_REQ];
            serial_port_stop_req_o <= reg_wdata_i[`PCS_BIT_UART_REQ];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // handshake agents, one per peripheral

    logic memif_stop_ack;               // memory interface ack
    logic usb_stop_ack;                 // usb ack
    logic serial_port_stop_ack;         // uart ack

    // each agent holds off its ack until the peripheral's bus goes quiet
    pcs_stop_agent u_memif_agent (
        .core_clk_i (core_clk_i),
        .srst_i     (srst_i),
        .stop_req_i (memif_stop_req_o),
        .bus_busy_i (memif_busy_i),
        .stop_ack_o (memif_stop_ack)
    );

    pcs_stop_agent u_usb_agent (
        .core_clk_i (core_clk_i),
        .srst_i     (srst_i),
        .stop_req_i (usb_stop_req_o),
        .bus_busy_i (usb_busy_i),
        .stop_ack_o (usb_stop_ack)
    );

    pcs_stop_agent u_serial_port_agent (
        .core_clk_i (core_clk_i),
        .srst_i     (srst_i),
        .stop_req_i (serial_port_stop_req_o),
        .bus_busy_i (serial_port_busy_i),
        .stop_ack_o (serial_port_stop_ack)
    );

    ////////////////////////////////////////////////////////////////////////////
    // peripheral clock gating registers

    logic [`PCS_DATA_W-1:0] gate_a;     // periph_gate_reg_a
    logic [`PCS_DATA_W-1:0] gate_b;     // periph_gate_reg_b

    // gating registers store the whole word; unsupported bits are kept so
    // software reads back what it wrote
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            gate_a <= `PCS_RST_GATE_A;
        end else if (wr_gate_a) begin
            gate_a <= reg_wdata_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            gate_b <= `PCS_RST_GATE_B;
        end else if (wr_gate_b) begin
            gate_b <= reg_wdata_i;
        end
    end

    // reset words as typed constants: a bare literal cannot be bit-selected
    localparam logic [`PCS_DATA_W-1:0] rst_gate_a = `PCS_RST_GATE_A;
    localparam logic [`PCS_DATA_W-1:0] rst_gate_b = `PCS_RST_GATE_B;
    localparam logic [2:0]             rst_clkgen = `PCS_RST_CLKGEN;

    // gate outputs follow the write in the same edge; no idle step needed.
    // the gate is not interlocked with the ack: firmware owns that order
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            memif_clk_gate_o       <= rst_gate_a[`PCS_BIT_GATE_MEMIF];
            serial_port_clk_gate_o <= rst_gate_a[`PCS_BIT_GATE_UART];
        end else if (wr_gate_a) begin
            memif_clk_gate_o       <= reg_wdata_i[`PCS_BIT_GATE_MEMIF];
            serial_port_clk_gate_o <= reg_wdata_i[`PCS_BIT_GATE_UART];
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            usb_clk_gate_o <= rst_gate_b[`PCS_BIT_GATE_USB];
        end else if (wr_gate_b) begin
            usb_clk_gate_o <= reg_wdata_i[`PCS_BIT_GATE_USB];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // clock generator bypass control

    // bypass only reroutes the system clock; the pll keeps running unless
    // its own power-down bit is set, so bypass alone saves little
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            clkgen_bypass_o         <= rst_clkgen[`PCS_BIT_CG_BYPASS];
            system_clock_from_rtc_o <= rst_clkgen[`PCS_BIT_CG_SRC_RTC];
            pll_pwrdn_o             <= rst_clkgen[`PCS_BIT_CG_PLL_PDN];
        end else if (wr_clkgen) begin
            clkgen_bypass_o         <= reg_wdata_i[`PCS_BIT_CG_BYPASS];
            system_clock_from_rtc_o <= reg_wdata_i[`PCS_BIT_CG_SRC_RTC];
            pll_pwrdn_o             <= reg_wdata_i[`PCS_BIT_CG_PLL_PDN];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read path

    logic [`PCS_DATA_W-1:0] next_rdata; // word selected by the address

    // reserved bits of the handshake and clock generator words read as zero; gating words read back whole; unmapped addresses read as zero
    always_comb begin
        next_rdata = '0;
        if (hit(reg_addr_i, `PCS_OFS_STOP_HS)) begin
            next_rdata[`PCS_BIT_MEMIF_REQ] = memif_stop_req_o;
            next_rdata[`PCS_BIT_MEMIF_ACK] = memif_stop_ack;
            next_rdata[`PCS_BIT_USB_REQ]   = usb_stop_req_o;
            next_rdata[`PCS_BIT_USB_ACK]   = usb_stop_ack;
            next_rdata[`PCS_BIT_UART_REQ]  = serial_port_stop_req_o;
            next_rdata[`PCS_BIT_UART_ACK]  = serial_port_stop_ack;
        end else if (hit(reg_addr_i, `PCS_OFS_GATE_A)) begin
            next_rdata = gate_a;
        end else if (hit(reg_addr_i, `PCS_OFS_GATE_B)) begin
            next_rdata = gate_b;
        end else if (hit(reg_addr_i, `PCS_OFS_CLKGEN)) begin
            next_rdata[`PCS_BIT_CG_BYPASS]  = clkgen_bypass_o;
            next_rdata[`PCS_BIT_CG_SRC_RTC] = system_clock_from_rtc_o;
            next_rdata[`PCS_BIT_CG_PLL_PDN] = pll_pwrdn_o;
        end
    end

    // read data valid only in the cycle after the strobe, zero otherwise
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            reg_rdata_o <= '0;
        end else if (reg_rd_i) begin
            reg_rdata_o <= next_rdata;
        end else begin
            reg_rdata_o <= '0;
        end
    end

endmodule // pcs_clock_stop

// ### tb/pcs_clock_stop_properties.sv
`timescale 1ns/10ps
`include "pcs_cfg.svh"

// pin-level watcher for the stop handshake and the register port
module pcs_clock_stop_properties (
    // clock and reset
    input wire logic                   core_clk_i,
    input wire logic                   srst_i,
    // register port
    input wire logic [`PCS_ADDR_W-1:0] reg_addr_i,
    input wire logic [`PCS_DATA_W-1:0] reg_wdata_i,
    input wire logic                   reg_wr_i,
    input wire logic                   reg_rd_i,
    input wire logic [`PCS_DATA_W-1:0] reg_rdata_o,
    // peripheral side
    input wire logic                   memif_busy_i,
    input wire logic                   usb_busy_i,
    input wire logic                   serial_port_busy_i,
    input wire logic                   memif_stop_req_o,
    input wire logic                   usb_stop_req_o,
    input wire logic                   serial_port_stop_req_o,
    // clock controls
    input wire logic                   memif_clk_gate_o,
    input wire logic                   usb_clk_gate_o,
    input wire logic                   serial_port_clk_gate_o,
    input wire logic                   clkgen_bypass_o,
    input wire logic                   system_clock_from_rtc_o,
    input wire logic                   pll_pwrdn_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (srst_i);
    wire  [2:0] req = {serial_port_stop_req_o, usb_stop_req_o, memif_stop_req_o};
    wire  [2:0] bsy = {serial_port_busy_i, usb_busy_i, memif_busy_i};
    wire  [2:0] gte = {serial_port_clk_gate_o, usb_clk_gate_o, memif_clk_gate_o};
    logic [2:0] idle_seen; // expected ack: quiet bus seen while draining
    logic [2:0] req_prev;  // request level at the previous edge
    logic       rd_hs;     // last cycle read the handshake word
    ////////////////////////////////////////////////////////////////////////
    // reference for the acks, kept apart from the read path; an agent only
    // starts draining one edge after it sees its request, so a quiet bus at
    // that very first edge does not count yet
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            idle_seen <= 3'h7;
            req_prev  <= 3'h7;
            rd_hs     <= 1'b0;
        end else begin
            idle_seen <= req & (idle_seen | (req_prev & ~bsy));
            req_prev  <= req;
            rd_hs     <= reg_rd_i && (reg_addr_i == `PCS_OFS_STOP_HS);
        end
    end
    sequence wr_at(logic [15:0] a);
        reg_wr_i && (reg_addr_i == a);
    endsequence
    ////////////////////////////////////////////////////////////////////////
    memif_ack_a: assert property (
        rd_hs |-> reg_rdata_o[1] == $past(idle_seen[0]))
        else $error("memif ack bit wrong");
    usb_ack_a: assert property (
        rd_hs |-> reg_rdata_o[3] == $past(idle_seen[1]))
        else $error("usb ack bit wrong");
    uart_ack_a: assert property (
        rd_hs |-> reg_rdata_o[5] == $past(idle_seen[2]))
        else $error("uart ack bit wrong");
    req_read_a: assert property (
        rd_hs |-> {reg_rdata_o[4], reg_rdata_o[2], reg_rdata_o[0]} == req)
        else $error("request bits read wrong");
    req_write_a: assert property (
        wr_at(`PCS_OFS_STOP_HS)
        |=> req == $past({reg_wdata_i[4], reg_wdata_i[2], reg_wdata_i[0]}))
        else $error("request write lost");
    gate_a_write_a: assert property (
        wr_at(`PCS_OFS_GATE_A)
        |=> {gte[2], gte[0]} == $past({reg_wdata_i[3], reg_wdata_i[1]}))
        else $error("gate a write lost");
    gate_b_write_a: assert property (
        wr_at(`PCS_OFS_GATE_B) |=> gte[1] == $past(reg_wdata_i[2]))
        else $error("gate b write lost");
    gate_hold_a: assert property (!reg_wr_i |=> $stable(gte))
        else $error("gate moved without write");
    clkgen_write_a: assert property (
        wr_at(`PCS_OFS_CLKGEN)
        |=> {pll_pwrdn_o, system_clock_from_rtc_o, clkgen_bypass_o}
            == $past(reg_wdata_i[2:0]))
        else $error("clock generator write lost");
    rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0000)
        else $error("read data not idle");
endmodule // pcs_clock_stop_properties

// ### tb/pcs_periph_model.sv
`timescale 1ns/10ps

// far-side peripherals, each running one bus transaction at a time
module pcs_periph_model (
    input  wire logic       core_clk_i,
    input  wire logic       srst_i,
    input  wire logic [2:0] start_i, // open a transaction, one pulse
    input  wire logic [7:0] len_i,   // transaction length in cycles
    input  wire logic [2:0] gate_i,  // clock stopped per peripheral
    output logic      [2:0] busy_o   // transaction open
);
    logic [7:0] left [3]; // cycles still to run
    // a stopped clock freezes the peripheral: nothing starts or ends
    always_ff @(posedge core_clk_i) begin
        for (int i = 0; i < 3; i++) begin
            if (srst_i) begin
                left[i] <= 8'h00;
            end else if (gate_i[i]) begin
                left[i] <= left[i];
            end else if (start_i[i]) begin
                left[i] <= len_i;
            end else if (left[i] != 8'h00) begin
                left[i] <= left[i] - 8'h01;
            end
        end
    end
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            busy_o[i] = (left[i] != 8'h00);
        end
    end
endmodule // pcs_periph_model

// ### tb/pcs_clock_stop_tb.sv
`timescale 1ns/10ps
`include "pcs_cfg.svh"

module pcs_clock_stop_tb;
    logic        core_clk_i, srst_i, reg_wr_i, reg_rd_i;
    logic [15:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
    logic        memif_stop_req_o, usb_stop_req_o, serial_port_stop_req_o;
    logic        memif_clk_gate_o, usb_clk_gate_o, serial_port_clk_gate_o;
    logic        clkgen_bypass_o, system_clock_from_rtc_o, pll_pwrdn_o;
    logic [2:0]  start;
    wire  [2:0]  busy;
    wire  [2:0]  gate = {serial_port_clk_gate_o, usb_clk_gate_o, memif_clk_gate_o};
    wire         memif_busy_i       = busy[0];
    wire         usb_busy_i         = busy[1];
    wire         serial_port_busy_i = busy[2];
    int          err_count, samples_checked, cycles;
    pcs_clock_stop dut (
        .core_clk_i             (core_clk_i),
        .srst_i                 (srst_i),
        .reg_addr_i             (reg_addr_i),
        .reg_wdata_i            (reg_wdata_i),
        .reg_wr_i               (reg_wr_i),
        .reg_rd_i               (reg_rd_i),
        .reg_rdata_o            (reg_rdata_o),
        .memif_busy_i           (memif_busy_i),
        .usb_busy_i             (usb_busy_i),
        .serial_port_busy_i     (serial_port_busy_i),
        .memif_stop_req_o       (memif_stop_req_o),
        .usb_stop_req_o         (usb_stop_req_o),
        .serial_port_stop_req_o (serial_port_stop_req_o),
        .memif_clk_gate_o       (memif_clk_gate_o),
        .usb_clk_gate_o         (usb_clk_gate_o),
        .serial_port_clk_gate_o (serial_port_clk_gate_o),
        .clkgen_bypass_o        (clkgen_bypass_o),
        .system_clock_from_rtc_o(system_clock_from_rtc_o),
        .pll_pwrdn_o            (pll_pwrdn_o)
    );
    pcs_periph_model u_periph (.core_clk_i(core_clk_i), .srst_i(srst_i), .start_i(start),
        .len_i(8'h14), .gate_i(gate), .busy_o(busy));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
        @(posedge core_clk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
        #1;
    endtask
    // read data stand only in the cycle after the read edge
    task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        chk(reg_rdata_o, exp);
    endtask
    task automatic test_done;
        $display("mismatches %0d, checks %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end
    // hang guard, far above the less than one hundred cycles the tests need
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            test_done;
        end
    end
    initial begin
        srst_i      = 1'b1;
        reg_wr_i    = 1'b0;
        reg_rd_i    = 1'b0;
        reg_addr_i  = 16'h0000;
        reg_wdata_i = 16'h0000;
        start       = 3'h0;
        repeat (4) @(posedge core_clk_i);
        srst_i <= 1'b0;
        rd_chk(`PCS_OFS_STOP_HS, 16'h003F);
        rd_chk(`PCS_OFS_GATE_A, 16'h0000);
        rd_chk(`PCS_OFS_GATE_B, 16'h0000);
        rd_chk(`PCS_OFS_CLKGEN, 16'h0000);
        rd_chk(16'h1C3B, 16'h0000);
        wr_reg(`PCS_OFS_STOP_HS, 16'h0000);
        rd_chk(`PCS_OFS_STOP_HS, 16'h0000);
        // usb mid-transaction when asked to stop; ack bits ignore writes
        @(posedge core_clk_i);
        start <= 3'h2;
        @(posedge core_clk_i);
        start <= 3'h0;
        wr_reg(`PCS_OFS_STOP_HS, 16'hFFFF);
        // agents start draining one edge after the request flop rises
        rd_chk(`PCS_OFS_STOP_HS, 16'h0015);
        rd_chk(`PCS_OFS_STOP_HS, 16'h0037);
        for (int i = 0; i < 100 && busy[1]; i++) @(posedge core_clk_i);
        rd_chk(`PCS_OFS_STOP_HS, 16'h003F);
        wr_reg(`PCS_OFS_GATE_B, 16'h0004);
        wr_reg(`PCS_OFS_GATE_A, 16'hFFFF);
        chk({13'h0, gate}, 16'h0007);
        rd_chk(`PCS_OFS_GATE_A, 16'hFFFF);
        wr_reg(`PCS_OFS_GATE_A, 16'h0000);
        wr_reg(`PCS_OFS_GATE_B, 16'h0000);
        chk({13'h0, gate}, 16'h0000);
        wr_reg(`PCS_OFS_STOP_HS, 16'h0010);
        rd_chk(`PCS_OFS_STOP_HS, 16'h0030);
        for (int v = 0; v < 8; v++) begin
            wr_reg(`PCS_OFS_CLKGEN, 16'(v));
            chk({13'h0, pll_pwrdn_o, system_clock_from_rtc_o, clkgen_bypass_o},
                16'(v));
        end
        @(posedge core_clk_i);
        srst_i <= 1'b1;
        @(posedge core_clk_i);
        srst_i <= 1'b0;
        rd_chk(`PCS_OFS_STOP_HS, 16'h003F);
        test_done;
    end
endmodule // pcs_clock_stop_tb

bind pcs_clock_stop pcs_clock_stop_properties u_props (
    .core_clk_i             (core_clk_i),
    .srst_i                 (srst_i),
    .reg_addr_i             (reg_addr_i),
    .reg_wdata_i            (reg_wdata_i),
    .reg_wr_i               (reg_wr_i),
    .reg_rd_i               (reg_rd_i),
    .reg_rdata_o            (reg_rdata_o),
    .memif_busy_i           (memif_busy_i),
    .usb_busy_i             (usb_busy_i),
    .serial_port_busy_i     (serial_port_busy_i),
    .memif_stop_req_o       (memif_stop_req_o),
    .usb_stop_req_o         (usb_stop_req_o),
    .serial_port_stop_req_o (serial_port_stop_req_o),
    .memif_clk_gate_o       (memif_clk_gate_o),
    .usb_clk_gate_o         (usb_clk_gate_o),
    .serial_port_clk_gate_o (serial_port_clk_gate_o),
    .clkgen_bypass_o        (clkgen_bypass_o),
    .system_clock_from_rtc_o(system_clock_from_rtc_o),
    .pll_pwrdn_o            (pll_pwrdn_o)
);
